// ### rtl/nps_regs.vh
// Register offsets, field positions, key bytes, reset values and timing
// counts for the non-volatile program sequencer.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef NPS_REGS_VH
`define NPS_REGS_VH

`define NPS_OFS_KEY1_0      12'h000
`define NPS_OFS_KEY1_1      12'h004
`define NPS_OFS_KEY1_2      12'h008
`define NPS_OFS_KEY1_3      12'h00C
`define NPS_OFS_KEY2_0      12'h010
`define NPS_OFS_KEY2_1      12'h014
`define NPS_OFS_KEY2_2      12'h018
`define NPS_OFS_KEY2_3      12'h01C
`define NPS_OFS_PROG_STAT   12'h020
`define NPS_OFS_PROG_CTRL   12'h024
`define NPS_OFS_CUST_STAT1  12'h028
`define NPS_OFS_CUST_STAT2  12'h02C
`define NPS_OFS_MAIN_CTRL   12'h030
`define NPS_OFS_IRQ_STAT    12'h034
`define NPS_OFS_IRQ_MASK    12'h038
`define NPS_OFS_CUST_DATA0  12'h040
`define NPS_OFS_CUST_DATA1  12'h044
`define NPS_OFS_CUST_WDATA  12'h048

`define NPS_KEY1_B0         8'h02
`define NPS_KEY1_B1         8'hB7
`define NPS_KEY1_B2         8'h78
`define NPS_KEY1_B3         8'hBC
`define NPS_KEY2_B0         8'h7E
`define NPS_KEY2_B1         8'h12
`define NPS_KEY2_B2         8'h08
`define NPS_KEY2_B3         8'h6F

`define NPS_GO_PAGE1        8'h01
`define NPS_GO_PAGE2        8'h03

// Program status fields.
`define NPS_STAT_DONE       0
`define NPS_STAT_UNLOCK     1
`define NPS_STAT_PERR       2
`define NPS_STAT_BUSY       3
// Customer page status fields.
`define NPS_CST_PAGE_A      0
`define NPS_CST_PROG_OK     1
`define NPS_CST_TRY         2
`define NPS_CST_OV_OK       3
`define NPS_CST_UV_OK       4
// Main control field.
`define NPS_MCTL_SOFT_RST   0
// Interrupt event fields.
`define NPS_IRQ_DONE        0
`define NPS_IRQ_PERR        1
`define NPS_IRQ_VFAIL       2

`define NPS_RESET_WORD      32'h0000_0000
`define NPS_CLK_NS          100
`define NPS_PROG_WAIT_NS    2000
`define NPS_VTEST_NS        500

`endif

// ### rtl/nps_nvm_cell.v
// Non-volatile customer page store with two page words and a fixed-time
// burn cycle. Factory space has no model here and no bus path at all.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "nps_regs.vh"
module nps_nvm_cell
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        burn_start,
   input  wire        burn_page,
   input  wire [31:0] burn_data,
   input  wire        vprog_stable,
   output reg         burn_end,
   output reg         burn_ok,
   output reg  [31:0] page0_q,
   output reg  [31:0] page1_q,
   output reg  [1:0]  used_q
);
   localparam integer BURN_CYC =
      `NPS_PROG_WAIT_NS / `NPS_CLK_NS - 2;

   reg [7:0]  cnt_q;
   reg        busy_q;
   reg        page_q;
   reg [31:0] data_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         busy_q    <= 1'b0;
         cnt_q     <= 8'h00;
         burn_end  <= 1'b0;
         burn_ok   <= 1'b0;
         page_q    <= 1'b0;
         data_q    <= `NPS_RESET_WORD;
      end
      else
      begin
         burn_end <= 1'b0;
         if (burn_start && !busy_q)
         begin
            busy_q <= 1'b1;
            cnt_q  <= 8'h00;
            page_q <= burn_page;
            data_q <= burn_data;
         end
         else if (busy_q)
         begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == BURN_CYC[7:0])
            begin
               busy_q   <= 1'b0;
               burn_end <= 1'b1;
               burn_ok  <= vprog_stable;
            end
         end
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         used_q  <= 2'b00;
         page0_q <= `NPS_RESET_WORD;
         page1_q <= `NPS_RESET_WORD;
      end
      else if (busy_q && cnt_q == BURN_CYC[7:0] && vprog_stable)
      begin
         used_q[page_q] <= 1'b1;
         if (page_q)
            page1_q <= data_q;
         else
            page0_q <= data_q;
      end
   end
endmodule

// ### rtl/nps_otp_sequencer.v
// Non-volatile program sequencer: key unlock, program launch, stability
// test, status and soft reset reload, behind an AXI4-Lite slave.
// Assumes one 10 MHz clock, synchronous active-low reset, and an
// asynchronous programming-voltage-good level on vprog_ok.
//
// Function
// - Factory space split off, never host visible.
// - Host reads and programs customer pages.
// - Key writes strictly sequential, nothing between.
// - Bad order or stray access voids unlock; code voids it on any write, but a read after unlock leaves it set.
// - Correct keys set unlock status bit.
// - After unlock, next write must be launch.
// - Value 0x01 programs page1, 0x03 page2.
// - Success sets done, other status bits zero.
// - Page1 success sets ok, try, voltage bits.
// - Page2 success also sets page_a bit.
// - Soft reset reloads registers from memory.
// - Voltage test fails: no program, try clear; code leaves try as is, clearing it only on a failed burn.
// - Unavailable page sets choice error, no program.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "nps_regs.vh"
module nps_otp_sequencer
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        vprog_ok,
   output reg         irq
);
   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_VTEST = 3'd1;
   localparam [2:0] ST_BURN  = 3'd2;
   localparam [2:0] ST_WAIT  = 3'd3;
   localparam integer VTEST_CYC = `NPS_VTEST_NS / `NPS_CLK_NS;

   // Write address/data capture; each side is taken independently.
   reg        aw_have_q, w_have_q;
   reg [11:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   wire       wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   wire       rd_fire = s_axi_arvalid && s_axi_arready;

   reg [2:0]  key_pos_q;
   reg        unlock_q;
   reg [2:0]  st_q;
   reg [3:0]  vcnt_q;
   reg        page_sel_q;
   reg [3:0]  prog_stat_q;
   reg [4:0]  cust1_q, cust2_q;
   reg [31:0] cust_wdata_q;
   reg [31:0] cust_data0_q, cust_data1_q;
   reg [2:0]  irq_stat_q, irq_mask_q;
   reg        soft_rst_q;
   reg        vp_s1_q, vp_s2_q, vp_s3_q, vp_lvl_q;
   reg        burn_start_q;

   wire        burn_end, burn_ok;
   wire [31:0] page0_w, page1_w;
   wire [1:0]  used_w;

   nps_nvm_cell u_cell
   (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .burn_start   (burn_start_q),
      .burn_page    (page_sel_q),
      .burn_data    (cust_wdata_q),
      .vprog_stable (vp_lvl_q),
      .burn_end     (burn_end),
      .burn_ok      (burn_ok),
      .page0_q      (page0_w),
      .page1_q      (page1_w),
      .used_q       (used_w)
   );

   // Expected key byte for each position of the eight-write sequence.
   reg [7:0]  key_exp;
   reg [11:0] key_ofs;
   always @*
   begin
      case (key_pos_q)
         3'd0: begin key_exp = `NPS_KEY1_B0; key_ofs = `NPS_OFS_KEY1_0; end
         3'd1: begin key_exp = `NPS_KEY1_B1; key_ofs = `NPS_OFS_KEY1_1; end
         3'd2: begin key_exp = `NPS_KEY1_B2; key_ofs = `NPS_OFS_KEY1_2; end
         3'd3: begin key_exp = `NPS_KEY1_B3; key_ofs = `NPS_OFS_KEY1_3; end
         3'd4: begin key_exp = `NPS_KEY2_B0; key_ofs = `NPS_OFS_KEY2_0; end
         3'd5: begin key_exp = `NPS_KEY2_B1; key_ofs = `NPS_OFS_KEY2_1; end
         3'd6: begin key_exp = `NPS_KEY2_B2; key_ofs = `NPS_OFS_KEY2_2; end
         default: begin key_exp = `NPS_KEY2_B3; key_ofs = `NPS_OFS_KEY2_3; end
      endcase
   end

   wire key_hit = wr_fire && aw_addr_q == key_ofs
                  && w_data_q[7:0] == key_exp && w_strb_q[0];
   wire is_ctrl = wr_fire && aw_addr_q == `NPS_OFS_PROG_CTRL;
   wire launch  = is_ctrl && unlock_q && st_q == ST_IDLE
                  && w_data_q[0];
   wire go_ok   = w_data_q[7:0] == `NPS_GO_PAGE1
                  || w_data_q[7:0] == `NPS_GO_PAGE2;
   wire rd_stat = rd_fire && s_axi_araddr == `NPS_OFS_IRQ_STAT;
   wire vfail   = st_q == ST_VTEST && !vp_lvl_q;

   reg [2:0] ev;
   always @*
   begin
      ev = 3'b000;
      ev[`NPS_IRQ_DONE]  = burn_end && burn_ok;
      ev[`NPS_IRQ_PERR]  = launch && (!go_ok || used_w[w_data_q[1]]);
      ev[`NPS_IRQ_VFAIL] = vfail || (burn_end && !burn_ok);
   end

   // Pin level filter: three stages, the change counts once 2 and 3 agree.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         vp_s1_q  <= 1'b0;
         vp_s2_q  <= 1'b0;
         vp_s3_q  <= 1'b0;
         vp_lvl_q <= 1'b0;
      end
      else
      begin
         vp_s1_q <= vprog_ok;
         vp_s2_q <= vp_s1_q;
         vp_s3_q <= vp_s2_q;
         if (vp_s2_q == vp_s3_q)
            vp_lvl_q <= vp_s3_q;
      end
   end

   // AXI write channel: one outstanding write, answer after both halves.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         aw_addr_q     <= 12'h000;
         w_data_q      <= `NPS_RESET_WORD;
         w_strb_q      <= 4'h0;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !s_axi_awready;
         s_axi_wready  <= !w_have_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q     <= 1'b1;
            aw_addr_q     <= {s_axi_awaddr[11:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > `NPS_OFS_CUST_WDATA) ?
                            2'b10 : 2'b00;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
         end
      end
   end

   // AXI read channel; factory space has no address, so it reads as error.
   reg [31:0] rd_mux;
   reg        rd_err;
   always @*
   begin
      rd_err = 1'b0;
      case (s_axi_araddr & 12'hFFC)
         `NPS_OFS_PROG_STAT:  rd_mux = {28'h000_0000, prog_stat_q};
         `NPS_OFS_CUST_STAT1: rd_mux = {27'h000_0000, cust1_q};
         `NPS_OFS_CUST_STAT2: rd_mux = {27'h000_0000, cust2_q};
         `NPS_OFS_IRQ_STAT:   rd_mux = {29'h000_0000, irq_stat_q};
         `NPS_OFS_IRQ_MASK:   rd_mux = {29'h000_0000, irq_mask_q};
         `NPS_OFS_CUST_DATA0: rd_mux = cust_data0_q;
         `NPS_OFS_CUST_DATA1: rd_mux = cust_data1_q;
         `NPS_OFS_CUST_WDATA: rd_mux = cust_wdata_q;
         default:
         begin
            rd_mux = `NPS_RESET_WORD;
            rd_err = (s_axi_araddr > `NPS_OFS_CUST_WDATA);
         end
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `NPS_RESET_WORD;
         s_axi_rresp   <= 2'b00;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (rd_fire)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_err ? 2'b10 : 2'b00;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Key sequencer and unlock state.
   always @(posedge aclk)
   begin
      if (!aresetn || soft_rst_q)
      begin
         key_pos_q <= 3'd0;
         unlock_q  <= 1'b0;
      end
      else if (wr_fire)
      begin
         if (unlock_q)
         begin
            unlock_q  <= 1'b0;
            key_pos_q <= 3'd0;
         end
         else if (key_hit)
         begin
            key_pos_q <= key_pos_q + 3'd1;
            if (key_pos_q == 3'd7)
               unlock_q <= 1'b1;
         end
         else
            key_pos_q <= 3'd0;
      end
      else if (rd_fire && key_pos_q != 3'd0)
         key_pos_q <= 3'd0;
   end

   // Program sequence, status registers and reload.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q         <= ST_IDLE;
         vcnt_q       <= 4'h0;
         page_sel_q   <= 1'b0;
         prog_stat_q  <= 4'h0;
         cust1_q      <= 5'h00;
         cust2_q      <= 5'h00;
         burn_start_q <= 1'b0;
         cust_wdata_q <= `NPS_RESET_WORD;
         cust_data0_q <= `NPS_RESET_WORD;
         cust_data1_q <= `NPS_RESET_WORD;
         irq_mask_q   <= 3'b000;
         soft_rst_q   <= 1'b0;
      end
      else
      begin
         burn_start_q <= 1'b0;
         soft_rst_q   <= 1'b0;
         if (wr_fire && aw_addr_q == `NPS_OFS_IRQ_MASK)
            irq_mask_q <= w_data_q[2:0];
         if (wr_fire && aw_addr_q == `NPS_OFS_CUST_WDATA && !unlock_q)
            cust_wdata_q <= w_data_q;
         if (wr_fire && aw_addr_q == `NPS_OFS_MAIN_CTRL
             && w_data_q[`NPS_MCTL_SOFT_RST] && st_q == ST_IDLE)
         begin
            soft_rst_q   <= 1'b1;
            cust_data0_q <= page0_w;
            cust_data1_q <= page1_w;
            prog_stat_q  <= 4'h0;
         end
         prog_stat_q[`NPS_STAT_UNLOCK] <= unlock_q;
         case (st_q)
            ST_IDLE:
               if (launch)
               begin
                  if (ev[`NPS_IRQ_PERR])
                     prog_stat_q <= 4'b0100;
                  else
                  begin
                     prog_stat_q <= 4'b1000;
                     page_sel_q  <= w_data_q[1];
                     vcnt_q      <= 4'h0;
                     st_q        <= ST_VTEST;
                  end
               end
            ST_VTEST:
               if (!vp_lvl_q)
               begin
                  prog_stat_q <= 4'h0;
                  st_q        <= ST_IDLE;
               end
               else if (vcnt_q == VTEST_CYC[3:0])
               begin
                  burn_start_q <= 1'b1;
                  st_q         <= ST_BURN;
               end
               else
                  vcnt_q <= vcnt_q + 4'h1;
            ST_BURN:
               st_q <= ST_WAIT;
            ST_WAIT:
               if (burn_end)
               begin
                  st_q <= ST_IDLE;
                  if (burn_ok)
                  begin
                     prog_stat_q <= 4'b0001;
                     cust1_q <= {1'b1, 1'b1, 1'b1, 1'b1,
                                 page_sel_q};
                     cust2_q <= page_sel_q ? 5'h00 : 5'h1E;
                  end
                  else
                  begin
                     prog_stat_q <= 4'h0;
                     cust1_q[`NPS_CST_TRY] <= 1'b0;
                  end
               end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // Sticky events, cleared by reading; a new event in the same cycle wins.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_q <= 3'b000;
         irq        <= 1'b0;
      end
      else
      begin
         irq_stat_q <= (rd_stat ? 3'b000 : irq_stat_q) | ev;
         irq        <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule

// ### test/nps_otp_sequencer_assertions.sv
// Bus answer and status field checks for the program sequencer.
// Assumes binding onto nps_otp_sequencer with one clock, sync reset.
`timescale 1ns/1ps
module nps_seq_chk
(
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_far_read;
      s_ar_take ##0 (s_axi_araddr[11:2] > 10'h012);
   endsequence
   sequence s_stat_read;
      s_ar_take ##0 (s_axi_araddr[11:2] == 10'h008);
   endsequence
   sequence s_cust_read;
      s_ar_take ##0 (s_axi_araddr[11:3] == 9'h005);
   endsequence
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_r_answer;
      s_ar_take |=> s_axi_rvalid;
   endproperty
   property p_b_answer;
      s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid;
   endproperty
   property p_no_aw_busy;
      s_axi_bvalid |-> !s_axi_awready;
   endproperty
   property p_factory_hidden;
      s_far_read |=> s_axi_rvalid && s_axi_rresp == 2'b10;
   endproperty
   property p_stat_width;
      s_stat_read |=> s_axi_rdata[31:4] == 28'h000_0000;
   endproperty
   property p_cust_width;
      s_cust_read |=> s_axi_rdata[31:5] == 27'h000_0000;
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before bready");
   a_r_hold: assert property (p_r_hold)
      else $error("read data changed before rready");
   a_r_answer: assert property (p_r_answer)
      else $error("read answer late");
   a_b_answer: assert property (p_b_answer)
      else $error("write answer late");
   a_no_aw_busy: assert property (p_no_aw_busy)
      else $error("address taken while response pending");
   a_factory_hidden: assert property (p_factory_hidden)
      else $error("space beyond the map not refused");
   a_stat_width: assert property (p_stat_width)
      else $error("program status has stray bits");
   a_cust_width: assert property (p_cust_width)
      else $error("customer status has stray bits");
endmodule
bind nps_otp_sequencer nps_seq_chk u_chk
(
   .aclk          (aclk),
   .aresetn       (aresetn),
   .s_axi_awready (s_axi_awready),
   .s_axi_wvalid  (s_axi_wvalid),
   .s_axi_wready  (s_axi_wready),
   .s_axi_bresp   (s_axi_bresp),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),
   .s_axi_araddr  (s_axi_araddr),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_arready (s_axi_arready),
   .s_axi_rdata   (s_axi_rdata),
   .s_axi_rresp   (s_axi_rresp),
   .s_axi_rvalid  (s_axi_rvalid),
   .s_axi_rready  (s_axi_rready)
);

// ### test/nps_axi_host.sv
// Host model: one AXI4-Lite write or read at a time, waiting on handshakes.
// Assumes its tasks are called one after another from the bench.
`timescale 1ns/1ps
module nps_axi_host
(
   input  wire        aclk,
   output reg  [11:0] s_axi_awaddr,
   output reg         s_axi_awvalid,
   input  wire        s_axi_awready,
   output reg  [31:0] s_axi_wdata,
   output reg  [3:0]  s_axi_wstrb,
   output reg         s_axi_wvalid,
   input  wire        s_axi_wready,
   input  wire [1:0]  s_axi_bresp,
   input  wire        s_axi_bvalid,
   output reg         s_axi_bready,
   output reg  [11:0] s_axi_araddr,
   output reg         s_axi_arvalid,
   input  wire        s_axi_arready,
   input  wire [31:0] s_axi_rdata,
   input  wire [1:0]  s_axi_rresp,
   input  wire        s_axi_rvalid,
   output reg         s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = 49'h0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = 14'h0;
      {s_axi_arvalid, s_axi_rready} = 2'b00;
   end
   // Released payloads are inverted so stale values cannot pass by luck.
   task wr(input [11:0] a, input [31:0] d, output [1:0] r);
      reg done;
      begin
         @(posedge aclk);
         s_axi_awaddr  <= a;
         s_axi_wdata   <= d;
         s_axi_wstrb   <= 4'hF;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid  <= 1'b1;
         s_axi_bready  <= 1'b1;
         done = 1'b0;
         while (!done)
         begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid)
            begin
               s_axi_awvalid <= 1'b0;
               s_axi_awaddr  <= ~a;
            end
            if (s_axi_wready && s_axi_wvalid)
            begin
               s_axi_wvalid <= 1'b0;
               s_axi_wdata  <= ~d;
            end
            if (s_axi_bvalid)
            begin
               r = s_axi_bresp;
               s_axi_bready <= 1'b0;
               done = 1'b1;
            end
         end
      end
   endtask
   task rd(input [11:0] a, output [31:0] d, output [1:0] r);
      reg done;
      begin
         @(posedge aclk);
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready  <= 1'b1;
         done = 1'b0;
         while (!done)
         begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid)
            begin
               s_axi_arvalid <= 1'b0;
               s_axi_araddr  <= ~a;
            end
            if (s_axi_rvalid)
            begin
               d = s_axi_rdata;
               r = s_axi_rresp;
               s_axi_rready <= 1'b0;
               done = 1'b1;
            end
         end
      end
   endtask
endmodule

// ### test/tb_top.sv
// Bench for the program sequencer: reset values, unlock, launch, status.
// Assumes the host model in nps_axi_host and the register header.
`timescale 1ns/1ps
`include "nps_regs.vh"
module tb_top;
   localparam integer PROGRAM_WAIT_TIME = (`NPS_PROG_WAIT_NS + `NPS_VTEST_NS) /
                              `NPS_CLK_NS + 10;
   reg         aclk, aresetn, vprog_ok;
   wire [11:0] awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [3:0]  wstrb;
   wire [1:0]  bresp, rresp;
   wire        awvalid, awready, wvalid, wready, bvalid, bready;
   wire        arvalid, arready, rvalid, rready, irq;
   integer     mismatches, check_count, i;
   reg  [31:0] d;
   reg  [1:0]  r;
   reg  [7:0]  key_tab [0:7];
   reg  [11:0] row_a [0:5];
   nps_axi_host host (.aclk(aclk), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   nps_otp_sequencer uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .vprog_ok(vprog_ok), .irq(irq));
   always #50 aclk = ~aclk;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rd_chk(input [11:0] a, input [31:0] e, input [31:0] m);
      begin
         host.rd(a, d, r);
         chk({30'h0, r}, 32'h0000_0000);
         chk(d & m, e);
      end
   endtask
   // Keys go one word apart, byte 0 only, in the order given.
   task keys(input integer first, input integer last);
      for (i = first; i <= last; i = i + 1)
         host.wr({i[9:0], 2'b00}, {24'h00_0000, key_tab[i]}, r);
   endtask
   task launch(input [7:0] v);
      begin
         keys(0, 7);
         host.wr(`NPS_OFS_PROG_CTRL, {24'h00_0000, v}, r);
         repeat (PROGRAM_WAIT_TIME) @(posedge aclk);
      end
   endtask
   task stop_test;
      begin
         $display("mismatches %0d check_count %0d", mismatches, check_count);
         if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      vprog_ok = 1'b1;
      mismatches = 0;
      check_count = 0;
      {key_tab[0], key_tab[1], key_tab[2], key_tab[3]} = 32'h02B7_78BC;
      {key_tab[4], key_tab[5], key_tab[6], key_tab[7]} = 32'h7E12_086F;
      {row_a[0], row_a[1], row_a[2]} = 36'h020_028_02C;
      {row_a[3], row_a[4], row_a[5]} = 36'h034_038_03C;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i = i + 1)
         rd_chk(row_a[i], 32'h0000_0000, 32'hFFFF_FFFF);
      host.rd(12'h050, d, r);
      chk({30'h0, r}, 32'h0000_0002);
      host.wr(12'h050, 32'h0000_0000, r);
      chk({30'h0, r}, 32'h0000_0002);
      host.wr(`NPS_OFS_IRQ_MASK, 32'h0000_0007, r);
      host.wr(`NPS_OFS_CUST_WDATA, 32'hA5C3_0F96, r);
      keys(0, 7);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0002, 32'hFFFF_FFFF);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0002, 32'hFFFF_FFFF);
      host.wr(`NPS_OFS_IRQ_MASK, 32'h0000_0007, r);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
      keys(0, 2);
      host.rd(`NPS_OFS_CUST_STAT1, d, r);
      keys(3, 7);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
      keys(0, 0);
      keys(2, 2);
      keys(1, 7);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
      vprog_ok <= 1'b0;
      launch(`NPS_GO_PAGE1);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
      rd_chk(`NPS_OFS_CUST_STAT1, 32'h0000_0000, 32'h0000_0004);
      chk({31'h0, irq}, 32'h0000_0001);
      rd_chk(`NPS_OFS_IRQ_STAT, 32'h0000_0004, 32'hFFFF_FFFF);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h0000_0000);
      launch(8'h05);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0004, 32'hFFFF_FFFF);
      vprog_ok <= 1'b1;
      repeat (5) @(posedge aclk);
      launch(`NPS_GO_PAGE1);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0001, 32'hFFFF_FFFF);
      rd_chk(`NPS_OFS_CUST_STAT1, 32'h0000_001E, 32'hFFFF_FFFF);
      rd_chk(`NPS_OFS_CUST_STAT2, 32'h0000_001E, 32'hFFFF_FFFF);
      launch(`NPS_GO_PAGE1);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0004, 32'hFFFF_FFFF);
      host.wr(`NPS_OFS_CUST_WDATA, 32'h5A3C_F069, r);
      launch(`NPS_GO_PAGE2);
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0001, 32'hFFFF_FFFF);
      rd_chk(`NPS_OFS_CUST_STAT1, 32'h0000_001F, 32'hFFFF_FFFF);
      rd_chk(`NPS_OFS_CUST_STAT2, 32'h0000_0000, 32'hFFFF_FFFF);
      host.wr(`NPS_OFS_MAIN_CTRL, 32'h0000_0001, r);
      repeat (5) @(posedge aclk);
      rd_chk(`NPS_OFS_CUST_DATA0, 32'hA5C3_0F96, 32'hFFFF_FFFF);
      rd_chk(`NPS_OFS_CUST_DATA1, 32'h5A3C_F069, 32'hFFFF_FFFF);
      keys(0, 7);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`NPS_OFS_PROG_STAT, 32'h0000_0000, 32'h0000_0002);
      stop_test;
   end
   initial
   begin
      repeat (5000) @(posedge aclk);
      mismatches = mismatches + 1;
      stop_test;
   end
endmodule
